//--- rtl/gpio_port_pkg.sv
// constants for the steerable two-port gpio block
// ==========================================================================
// ==========================================================================
package gpio_port_pkg;

   // ======================================================================
   // register offsets on the plain register port
   localparam logic [3:0] DIR_D_ADDR   = 4'h0;
   localparam logic [3:0] DIR_E_ADDR   = 4'h1;
   localparam logic [3:0] LEVEL_D_ADDR = 4'h2;
   localparam logic [3:0] LEVEL_E_ADDR = 4'h3;
   localparam logic [3:0] LATCH_D_ADDR = 4'h4;
   localparam logic [3:0] LATCH_E_ADDR = 4'h5;
   localparam logic [3:0] ANSEL_D_ADDR = 4'h6;
   localparam logic [3:0] ANSEL_E_ADDR = 4'h7;
   localparam logic [3:0] WPU_D_ADDR   = 4'h8;
   localparam logic [3:0] WPU_E_ADDR   = 4'h9;
   localparam logic [3:0] STEER_ADDR   = 4'hA;

   // ======================================================================
   // values after reset
   localparam logic [7:0] DIR_RESET    = 8'hFF;
   localparam logic [7:0] LATCH_RESET  = 8'h00;
   localparam logic [7:0] ANSEL_RESET  = 8'hFF;
   localparam logic [7:0] WPU_RESET    = 8'h00;
   localparam logic [7:0] STEER_RESET  = 8'h00;

   // ======================================================================
   // pin index of each steered output, steer bit 7 down to bit 0
   localparam logic [7:0][2:0] STEER_PIN = {3'h3, 3'h4, 3'h0, 3'h1, 3'h2, 3'h7, 3'h5, 3'h6};

   localparam int NUM_PORTS = 2;

endpackage : gpio_port_pkg

//--- rtl/gpio_port.sv
// two eight-pin gpio ports with pwm output steering
module gpio_port (
   input  wire logic       CLOCK_IN,
   input  wire logic       RSTN_IN,
   input  wire logic [3:0] ADDR_IN,
   input  wire logic [7:0] WDATA_IN,
   input  wire logic       WR_IN,
   input  wire logic       RD_IN,
   output logic      [7:0] RDATA_OUT,
   input  wire logic [7:0] PORT_D_PIN_IN,
   output logic      [7:0] PORT_D_PIN_OUT,
   output logic      [7:0] PORT_D_PIN_OE_OUT,
   output logic      [7:0] PORT_D_PULLUP_OUT,
   output logic      [7:0] PORT_D_DIGITAL_OUT,
   input  wire logic [7:0] PORT_E_PIN_IN,
   output logic      [7:0] PORT_E_PIN_OUT,
   output logic      [7:0] PORT_E_PIN_OE_OUT,
   output logic      [7:0] PORT_E_PULLUP_OUT,
   output logic      [7:0] PORT_E_DIGITAL_OUT,
   input  wire logic [7:0] PWM_EN_IN,
   input  wire logic [7:0] PWM_DATA_IN,
   input  wire logic [7:0] SEG_EN_D_IN,
   input  wire logic [7:0] SEG_DATA_D_IN,
   input  wire logic [7:0] SEG_EN_E_IN,
   input  wire logic [7:0] SEG_DATA_E_IN
);

   // =======================================================================
   // state
   logic [1:0][7:0] dir_r;
   logic [1:0][7:0] latch_r;
   logic [1:0][7:0] ansel_r;
   logic [1:0][7:0] wpu_r;
   logic      [7:0] steer_r;
   logic [1:0][7:0] pin_meta_r;
   logic [1:0][7:0] pin_sync_r;
   logic [1:0][7:0] digital_in;
   logic [1:0][7:0] pwm_en;
   logic [1:0][7:0] pwm_dat;
   logic [1:0][7:0] seg_en;
   logic [1:0][7:0] seg_dat;
   logic [1:0][7:0] ovr_en;
   logic [1:0][7:0] drv_nxt;
   logic [1:0][7:0] oe_nxt;
   logic [1:0][7:0] drv_r;
   logic [1:0][7:0] oe_r;
   logic [1:0][7:0] pull_r;
   logic      [7:0] rdata_nxt;

   assign seg_en  = {SEG_EN_E_IN, SEG_EN_D_IN};
   assign seg_dat = {SEG_DATA_E_IN, SEG_DATA_D_IN};

   // =======================================================================
   // pin synchroniser, two stages
   always_ff @(posedge CLOCK_IN) begin
      if (!RSTN_IN) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
      end else begin
         pin_meta_r <= {PORT_E_PIN_IN, PORT_D_PIN_IN};
         pin_sync_r <= pin_meta_r;
      end
   end

   // analog pins read as zero on every digital path
   assign digital_in = pin_sync_r & ~ansel_r;

   // =======================================================================
   // register writes
   always_ff @(posedge CLOCK_IN) begin
      if (!RSTN_IN) begin
         dir_r <= {gpio_port_pkg::DIR_RESET, gpio_port_pkg::DIR_RESET};
      end else if (WR_IN) begin
         unique case (ADDR_IN)
            gpio_port_pkg::DIR_D_ADDR: dir_r[0] <= WDATA_IN;
            gpio_port_pkg::DIR_E_ADDR: dir_r[1] <= WDATA_IN;
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RSTN_IN) begin
         latch_r <= {gpio_port_pkg::LATCH_RESET, gpio_port_pkg::LATCH_RESET};
      end else if (WR_IN) begin
         unique case (ADDR_IN)
            gpio_port_pkg::LATCH_D_ADDR, gpio_port_pkg::LEVEL_D_ADDR: latch_r[0] <= WDATA_IN;
            gpio_port_pkg::LATCH_E_ADDR, gpio_port_pkg::LEVEL_E_ADDR: latch_r[1] <= WDATA_IN;
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RSTN_IN) begin
         ansel_r <= {gpio_port_pkg::ANSEL_RESET, gpio_port_pkg::ANSEL_RESET};
         wpu_r   <= {gpio_port_pkg::WPU_RESET, gpio_port_pkg::WPU_RESET};
      end else if (WR_IN) begin
         unique case (ADDR_IN)
            gpio_port_pkg::ANSEL_D_ADDR: ansel_r[0] <= WDATA_IN;
            gpio_port_pkg::ANSEL_E_ADDR: ansel_r[1] <= WDATA_IN;
            gpio_port_pkg::WPU_D_ADDR:   wpu_r[0]   <= WDATA_IN;
            gpio_port_pkg::WPU_E_ADDR:   wpu_r[1]   <= WDATA_IN;
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RSTN_IN) begin
         steer_r <= gpio_port_pkg::STEER_RESET;
      end else if (WR_IN && ADDR_IN == gpio_port_pkg::STEER_ADDR) begin
         steer_r <= WDATA_IN;
      end
   end

   // =======================================================================
   // register reads, data in the following cycle
   always_comb begin
      unique case (ADDR_IN)
         gpio_port_pkg::DIR_D_ADDR:   rdata_nxt = dir_r[0];
         gpio_port_pkg::DIR_E_ADDR:   rdata_nxt = dir_r[1];
         gpio_port_pkg::LEVEL_D_ADDR: rdata_nxt = digital_in[0];
         gpio_port_pkg::LEVEL_E_ADDR: rdata_nxt = digital_in[1];
         gpio_port_pkg::LATCH_D_ADDR: rdata_nxt = latch_r[0];
         gpio_port_pkg::LATCH_E_ADDR: rdata_nxt = latch_r[1];
         gpio_port_pkg::ANSEL_D_ADDR: rdata_nxt = ansel_r[0];
         gpio_port_pkg::ANSEL_E_ADDR: rdata_nxt = ansel_r[1];
         gpio_port_pkg::WPU_D_ADDR:   rdata_nxt = wpu_r[0];
         gpio_port_pkg::WPU_E_ADDR:   rdata_nxt = wpu_r[1];
         gpio_port_pkg::STEER_ADDR:   rdata_nxt = steer_r;
         default:                     rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RSTN_IN) begin
         RDATA_OUT <= 8'h00;
      end else if (RD_IN) begin
         RDATA_OUT <= rdata_nxt;
      end else begin
         RDATA_OUT <= 8'h00;
      end
   end

   // =======================================================================
   // steering: set bit selects port d pin, clear selects port e pin
   for (genvar k = 0; k < 8; k++) begin : g_steer
      localparam int P = int'(gpio_port_pkg::STEER_PIN[k]);
      assign pwm_en[0][P]  = PWM_EN_IN[k] & steer_r[k];
      assign pwm_en[1][P]  = PWM_EN_IN[k] & ~steer_r[k];
      assign pwm_dat[0][P] = PWM_DATA_IN[k];
      assign pwm_dat[1][P] = PWM_DATA_IN[k];
   end

   // =======================================================================
   // output priority: segment, then steered pwm, then latch
   assign ovr_en = seg_en | pwm_en;

   always_comb begin
      for (int p = 0; p < gpio_port_pkg::NUM_PORTS; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (seg_en[p][b]) begin
               drv_nxt[p][b] = seg_dat[p][b];
               oe_nxt[p][b]  = 1'b1;
            end else if (pwm_en[p][b]) begin
               drv_nxt[p][b] = pwm_dat[p][b];
               oe_nxt[p][b]  = 1'b1;
            end else begin
               drv_nxt[p][b] = latch_r[p][b];
               oe_nxt[p][b]  = ~dir_r[p][b];
            end
         end
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RSTN_IN) begin
         drv_r  <= '0;
         oe_r   <= '0;
         pull_r <= '0;
      end else begin
         drv_r  <= drv_nxt;
         oe_r   <= oe_nxt;
         pull_r <= wpu_r & dir_r & ~ovr_en;
      end
   end

   assign PORT_D_PIN_OUT     = drv_r[0];
   assign PORT_D_PIN_OE_OUT  = oe_r[0];
   assign PORT_D_PULLUP_OUT  = pull_r[0];
   assign PORT_D_DIGITAL_OUT = digital_in[0];
   assign PORT_E_PIN_OUT     = drv_r[1];
   assign PORT_E_PIN_OE_OUT  = oe_r[1];
   assign PORT_E_PULLUP_OUT  = pull_r[1];
   assign PORT_E_DIGITAL_OUT = digital_in[1];

   // =======================================================================
   // assertions
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RSTN_IN);

   a_analog_reset: assert property (
      $rose(RSTN_IN) |-> ansel_r == {gpio_port_pkg::ANSEL_RESET, gpio_port_pkg::ANSEL_RESET})
      else $error("analog select not set after reset");

   a_level_write_latch: assert property (
      WR_IN && ADDR_IN == gpio_port_pkg::LEVEL_D_ADDR |=> latch_r[0] == $past(WDATA_IN))
      else $error("pin level write did not reach latch");

   a_latch_readback: assert property (
      RD_IN && ADDR_IN == gpio_port_pkg::LATCH_E_ADDR |=> RDATA_OUT == $past(latch_r[1]))
      else $error("latch read wrong");

   a_level_analog_zero: assert property (
      RD_IN && ADDR_IN == gpio_port_pkg::LEVEL_D_ADDR |=> (RDATA_OUT & $past(ansel_r[0])) == 8'h00)
      else $error("analog pin read nonzero");

   a_level_readback: assert property (
      RD_IN && ADDR_IN == gpio_port_pkg::LEVEL_D_ADDR && ansel_r[0] == 8'h00
      |=> RDATA_OUT == $past(PORT_D_PIN_IN, 3))
      else $error("pin level read wrong");

   a_input_no_drive: assert property (
      ##1 (PORT_D_PIN_OE_OUT & $past(dir_r[0]) & ~$past(ovr_en[0])) == 8'h00)
      else $error("input pin driven");

   a_dir_pattern: assert property (
      WR_IN && ADDR_IN == gpio_port_pkg::DIR_D_ADDR && WDATA_IN == 8'h38
      |=> (ovr_en[0] == 8'h00 && !(WR_IN && ADDR_IN == gpio_port_pkg::DIR_D_ADDR))
      |=> PORT_D_PIN_OE_OUT[5:0] == 6'h07)
      else $error("direction pattern misapplied");

   a_steer_keeps_dir: assert property (
      WR_IN && ADDR_IN == gpio_port_pkg::STEER_ADDR |=> dir_r == $past(dir_r))
      else $error("steering write changed direction");

   a_selected_pin: assert property (
      PWM_EN_IN[0] && steer_r[0] && !SEG_EN_D_IN[6]
      |=> PORT_D_PIN_OE_OUT[6] && PORT_D_PIN_OUT[6] == $past(PWM_DATA_IN[0]))
      else $error("steered output missing on selected pin");

   a_unselected_pin: assert property (
      PWM_EN_IN[0] && !steer_r[0] && !SEG_EN_D_IN[6]
      |=> PORT_D_PIN_OUT[6] == $past(latch_r[0][6]) && PORT_D_PIN_OE_OUT[6] == !$past(dir_r[0][6]))
      else $error("unselected pin disturbed");

   a_priority_seg: assert property (
      SEG_EN_E_IN[3] |=> PORT_E_PIN_OE_OUT[3] && PORT_E_PIN_OUT[3] == $past(SEG_DATA_E_IN[3]))
      else $error("priority owner lost pin");

   a_pullup_gate: assert property (
      ##1 (PORT_E_PULLUP_OUT & ~$past(wpu_r[1] & dir_r[1])) == 8'h00)
      else $error("pull-up on while disabled or output");

   a_latch_d_readback: assert property (
      RD_IN && ADDR_IN == gpio_port_pkg::LATCH_D_ADDR |=> RDATA_OUT == $past(latch_r[0]))
      else $error("port d latch read wrong");

   a_level_e_write: assert property (
      WR_IN && ADDR_IN == gpio_port_pkg::LEVEL_E_ADDR |=> latch_r[1] == $past(WDATA_IN))
      else $error("port e level write did not reach latch");

   a_steer_readback: assert property (
      RD_IN && ADDR_IN == gpio_port_pkg::STEER_ADDR |=> RDATA_OUT == $past(steer_r))
      else $error("steering read wrong");

   a_rdata_idle: assert property (
      !RD_IN |=> RDATA_OUT == 8'h00)
      else $error("read data not idle");

   a_selected_pin_e: assert property (
      PWM_EN_IN[7] && !steer_r[7] && !SEG_EN_E_IN[3]
      |=> PORT_E_PIN_OE_OUT[3] && PORT_E_PIN_OUT[3] == $past(PWM_DATA_IN[7]))
      else $error("steered output missing on port e pin");

   a_unselected_pin_e: assert property (
      PWM_EN_IN[7] && steer_r[7] && !SEG_EN_E_IN[3]
      |=> PORT_E_PIN_OUT[3] == $past(latch_r[1][3]) && PORT_E_PIN_OE_OUT[3] == !$past(dir_r[1][3]))
      else $error("unselected port e pin disturbed");

   a_digital_analog_zero: assert property (
      (PORT_E_DIGITAL_OUT & ansel_r[1]) == 8'h00)
      else $error("analog pin reached digital input");

   a_steer_e_keeps_dir: assert property (
      WR_IN && ADDR_IN == gpio_port_pkg::STEER_ADDR |=> dir_r[1] == $past(dir_r[1]))
      else $error("steering write changed port e direction");

   c_steer_d: cover property (WR_IN && ADDR_IN == gpio_port_pkg::STEER_ADDR ##1 PWM_EN_IN != 8'h00);
   c_seg_priority: cover property (SEG_EN_D_IN != 8'h00 && PWM_EN_IN != 8'h00);
   c_dir_pattern: cover property (WR_IN && ADDR_IN == gpio_port_pkg::DIR_D_ADDR && WDATA_IN == 8'h38);
   c_level_read: cover property (RD_IN && ADDR_IN == gpio_port_pkg::LEVEL_E_ADDR && ansel_r[1] == 8'h00);

endmodule : gpio_port

//--- testbench/pin_model.sv
// package pin model: driven, pulled up or set from outside
module pin_model (
   input  wire logic [7:0] OE_IN,
   input  wire logic [7:0] DRV_IN,
   input  wire logic [7:0] PULL_IN,
   input  wire logic [7:0] EXT_IN,
   output logic      [7:0] PIN_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   // undriven pins without pull-up follow the outside world
   assign PIN_OUT = (OE_IN & DRV_IN) | (~OE_IN & (PULL_IN | EXT_IN));
endmodule : pin_model

//--- testbench/gpio_port_tb.sv
// self-checking bench for the gpio port block
module gpio_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic            clock_in = 1'b0;
   logic            rstn_in  = 1'b0;
   logic [3:0]      addr     = 4'h0;
   logic [7:0]      wdata    = 8'h00;
   logic            wr_en    = 1'b0;
   logic            rd_en    = 1'b0;
   wire  [7:0]      rdata;
   logic [7:0]      pwm_en   = 8'h00;
   logic [7:0]      pwm_d    = 8'h00;
   logic [7:0]      steer, eoe, eout, epu, d;
   logic [1:0][7:0] seg_en   = '0;
   logic [1:0][7:0] seg_d    = '0;
   logic [1:0][7:0] ext      = '0;
   logic [1:0][7:0] dir, lat, ans, wpu;
   wire  [1:0][7:0] poe, pout, ppu, pdig, pin;
   int              err_count = 0;
   int              cmp_count = 0;
   int              seed      = 11;

   gpio_port uut (
      .CLOCK_IN(clock_in), .RSTN_IN(rstn_in), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_en),
      .RD_IN(rd_en), .RDATA_OUT(rdata), .PORT_D_PIN_IN(pin[0]), .PORT_D_PIN_OUT(pout[0]),
      .PORT_D_PIN_OE_OUT(poe[0]), .PORT_D_PULLUP_OUT(ppu[0]), .PORT_D_DIGITAL_OUT(pdig[0]),
      .PORT_E_PIN_IN(pin[1]), .PORT_E_PIN_OUT(pout[1]), .PORT_E_PIN_OE_OUT(poe[1]),
      .PORT_E_PULLUP_OUT(ppu[1]), .PORT_E_DIGITAL_OUT(pdig[1]), .PWM_EN_IN(pwm_en), .PWM_DATA_IN(pwm_d),
      .SEG_EN_D_IN(seg_en[0]), .SEG_DATA_D_IN(seg_d[0]), .SEG_EN_E_IN(seg_en[1]), .SEG_DATA_E_IN(seg_d[1])
   );
   pin_model pm0 (.OE_IN(poe[0]), .DRV_IN(pout[0]), .PULL_IN(ppu[0]), .EXT_IN(ext[0]), .PIN_OUT(pin[0]));
   pin_model pm1 (.OE_IN(poe[1]), .DRV_IN(pout[1]), .PULL_IN(ppu[1]), .EXT_IN(ext[1]), .PIN_OUT(pin[1]));

   always #10 clock_in = ~clock_in;

   // ======================================================================
   // bus tasks, comparison and closing
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock_in);
      addr  <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clock_in);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clock_in);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clock_in);
      rd_en <= 1'b0;
      #1;
      v = rdata;
   endtask : rd

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   // ======================================================================
   // expected pin state: segment over steered pwm over latch
   function automatic void expect_port(input int p);
      logic [7:0] ovr;
      ovr  = seg_en[p];
      eout = lat[p];
      for (int b = 0; b < 8; b++) begin
         if (pwm_en[b] && steer[b] == (p == 0)) begin
            ovr[gpio_port_pkg::STEER_PIN[b]]  = 1'b1;
            eout[gpio_port_pkg::STEER_PIN[b]] = pwm_d[b];
         end
      end
      eout = (eout & ~seg_en[p]) | (seg_d[p] & seg_en[p]);
      eoe  = ~dir[p] | ovr;
      epu  = wpu[p] & dir[p] & ~ovr;
   endfunction : expect_port

   initial begin
      repeat (20000) @(posedge clock_in);
      err_count++;
      complete_run();
   end

   initial begin
      logic [7:0] v;
      repeat (2) @(posedge clock_in);
      rstn_in <= 1'b1;
      for (int a = 0; a < 16; a++) begin
         rd(4'(a), v);
         chk("reset value", v, (a < 2 || a == 6 || a == 7) ? 8'hFF : 8'h00);
      end
      $display("reset test done");
      for (int i = 0; i < 24; i++) begin
         for (int p = 0; p < 2; p++) begin
            dir[p] = (i == 0 && p == 0) ? 8'h38 : 8'($random(seed));
            lat[p] = 8'($random(seed));
            ans[p] = (i == 0) ? 8'h00 : 8'($random(seed));
            wpu[p] = 8'($random(seed));
         end
         steer = 8'($random(seed));
         @(posedge clock_in);
         pwm_en <= (i == 0) ? 8'h00 : 8'($random(seed));
         pwm_d  <= 8'($random(seed));
         seg_en <= (i == 0) ? 16'h0000 : 16'($random(seed) & $random(seed));
         seg_d  <= 16'($random(seed));
         ext    <= 16'($random(seed));
         for (int p = 0; p < 2; p++) begin
            wr(gpio_port_pkg::DIR_D_ADDR + 4'(p), dir[p]);
            wr((i % 2 ? gpio_port_pkg::LEVEL_D_ADDR : gpio_port_pkg::LATCH_D_ADDR) + 4'(p), lat[p]);
            wr(gpio_port_pkg::ANSEL_D_ADDR + 4'(p), ans[p]);
            wr(gpio_port_pkg::WPU_D_ADDR + 4'(p), wpu[p]);
         end
         wr(gpio_port_pkg::STEER_ADDR, steer);
         repeat (6) @(posedge clock_in);
         #1;
         for (int p = 0; p < 2; p++) begin
            expect_port(p);
            chk("output enable", poe[p], eoe);
            chk("pin drive", pout[p] & eoe, eout & eoe);
            chk("pull-up", ppu[p], epu);
            d = ((eoe & eout) | (~eoe & (epu | ext[p]))) & ~ans[p];
            chk("digital in", pdig[p], d);
            rd(gpio_port_pkg::LEVEL_D_ADDR + 4'(p), v);
            chk("level read", v, d);
            rd(gpio_port_pkg::LATCH_D_ADDR + 4'(p), v);
            chk("latch read", v, lat[p]);
            rd(gpio_port_pkg::DIR_D_ADDR + 4'(p), v);
            chk("direction read", v, dir[p]);
            rd(gpio_port_pkg::ANSEL_D_ADDR + 4'(p), v);
            chk("analog select read", v, ans[p]);
            rd(gpio_port_pkg::WPU_D_ADDR + 4'(p), v);
            chk("pull-up enable read", v, wpu[p]);
         end
         rd(gpio_port_pkg::STEER_ADDR, v);
         chk("steer read", v, steer);
         $display("random pass %0d done", i);
      end
      complete_run();
   end
endmodule : gpio_port_tb
